// ### dv/fuar_checker.sv
`timescale 1ns/100ps
module fuar_checker
  import fuar_pkg::*;
(
  // Clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // Bus answers
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_arvalid,
  input wire logic [7:0]   s_axi_araddr,
  input wire logic         s_axi_rvalid,
  input wire logic [31:0]  s_axi_rdata,
  // Launch
  input wire logic         launch_valid,
  input wire fuar_launch_t launch_cmd
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////
  // Key reads, launch timing, masking per code
  key_reads_zero_a: assert property (
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == OFF_KEY |=> s_axi_rdata == ZERO_WORD)
    else $error("key read not zero");
  launch_on_resp_a: assert property (
    launch_valid |-> $rose(s_axi_bvalid)) else $error("launch off response");
  launch_pulse_a: assert property (
    launch_valid |=> !launch_valid) else $error("launch too long");
  page_mask_a: assert property (
    launch_valid && launch_cmd.op == OP_PAGE |-> launch_cmd.addr[13:0] == 14'h0)
    else $error("page bits kept");
  row_mask_a: assert property (
    launch_valid && launch_cmd.op == OP_ROW |-> launch_cmd.addr[10:0] == 11'h0)
    else $error("row bits kept");
  word_mask_a: assert property (
    launch_valid && launch_cmd.op == OP_WORD |-> launch_cmd.addr[1:0] == 2'h0)
    else $error("word bits kept");
  quad_mask_a: assert property (
    launch_valid && launch_cmd.op == OP_QUAD |-> launch_cmd.addr[3:0] == 4'h0)
    else $error("quad bits kept");
  addr_use_a: assert property (
    launch_valid |-> launch_cmd.addr_used == (launch_cmd.op inside {[4'h1:4'h4]})
    && (launch_cmd.addr_used || launch_cmd.addr == 32'h0)) else $error("address use wrong");
  // Main scenarios reached
  cover property (launch_valid && launch_cmd.op == OP_PAGE);
  cover property (launch_valid && !launch_cmd.addr_used);
  cover property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == OFF_KEY);
endmodule : fuar_checker

bind fuar_regs fuar_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .launch_valid(launch_valid), .launch_cmd(launch_cmd));

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top import fuar_pkg::*; ;
  logic         aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, launch_valid;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, m_addr;
  logic [3:0]   wstrb, m_op;
  logic         m_ref;
  logic [1:0]   bresp, rresp;
  fuar_launch_t launch_cmd, m_cmd;
  int           err_count, checks_done, cyc, m_st;

  fuar_regs uut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .launch_valid(launch_valid), .launch_cmd(launch_cmd));

  //////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic cmp_d(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp_d

  task automatic cmp_l(input logic [37:0] e, input logic [37:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp_l

  // Plain reset keeps the target address; p adds power-on
  task automatic rst(input logic p);
    aresetn <= 1'b0;
    por_n   <= ~p;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_n   <= 1'b1;
    m_st = 0;
    m_op = 4'h0;
    m_ref = 1'b0;
    m_cmd = '0;
    if (p) m_addr = 32'h0;
  endtask : rst

  // Model first, then the bus; launch sampled with the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [37:0] el;
    logic [1:0]  er;
    int          n;
    er = RESP_OKAY;
    el = {1'b0, m_cmd};
    case (a)
      OFF_KEY:  m_st = s != 4'hf ? 0 : d == KEY_FIRST ? 1 : (d == KEY_SECOND && m_st == 1) ? 2 : 0;
      // Any write but a key word breaks the unlock sequence
      OFF_ADDR: begin
        for (int i = 0; i < 4; i++) if (s[i]) m_addr[8*i +: 8] = d[8*i +: 8];
        m_st = 0;
      end
      OFF_CTRL: begin
        m_op = s[0] ? d[3:0] : m_op;
        n = m_op == OP_PAGE ? 14 : m_op == OP_ROW ? 11 : m_op == OP_QUAD ? 4 : m_op == OP_WORD ? 2 : 0;
        if (d[15] && s[1]) begin
          m_ref = m_st != 2;
          if (m_st == 2) begin
            m_cmd = {m_op, n > 0, n > 0 ? (m_addr >> n) << n : 32'h0};
            el = {1'b1, m_cmd};
          end
        end
        m_st = 0;
      end
      default: begin
        er = RESP_SLVERR;
        m_st = 0;
      end
    endcase
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp_d({30'h0, er}, {30'h0, bresp});
    cmp_l(el, {launch_valid, launch_cmd});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] ed;
    logic [1:0]  er;
    ed = a == OFF_ADDR ? m_addr : a == OFF_CTRL ? {28'h0, m_op} : a == OFF_LAST ? m_cmd.addr :
         a == OFF_STAT ? {29'h0, m_cmd.addr_used, m_ref, m_st == 2} : ZERO_WORD;
    er = a inside {OFF_KEY, OFF_ADDR, OFF_CTRL, OFF_STAT, OFF_LAST} ? RESP_OKAY : RESP_SLVERR;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp_d(ed, rdata);
    cmp_d({30'h0, er}, {30'h0, rresp});
  endtask : rd

  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {err_count, checks_done, cyc} = '0;
    aclk = 1'b0;
    m_addr = 32'h0;
    void'($urandom(32'h08449727));
    rst(1'b1);
    rd(OFF_KEY);
    rd(OFF_ADDR);
    rd(8'hfc);
    wr(8'hfc, 32'h1, 4'hf);
    // Codes 0 to 7 and 15, with a stale code stored before unlocking
    for (int k = 0; k < 9; k++) begin
      wr(OFF_ADDR, $urandom, 4'hf);
      wr(OFF_CTRL, $urandom % 16, 4'hf);
      wr(OFF_KEY, KEY_FIRST, 4'hf);
      rd(OFF_KEY);
      wr(OFF_KEY, KEY_SECOND, 4'hf);
      rd(OFF_STAT);
      wr(OFF_CTRL, 32'h8000 | (k < 8 ? k : 15), 4'hf);
      rd(OFF_LAST);
      rd(OFF_STAT);
    end
    // Broken, partial and restarted unlock sequences
    wr(OFF_CTRL, 32'h8004, 4'hf);
    rd(OFF_STAT);
    wr(OFF_KEY, KEY_FIRST, 4'hf);
    wr(OFF_ADDR, 32'h5a, 4'h1);
    wr(OFF_KEY, KEY_SECOND, 4'hf);
    wr(OFF_CTRL, 32'h8004, 4'hf);
    wr(OFF_KEY, KEY_FIRST, 4'h7);
    wr(OFF_KEY, KEY_SECOND, 4'hf);
    wr(OFF_CTRL, 32'h8001, 4'hf);
    wr(OFF_KEY, KEY_FIRST, 4'hf);
    wr(OFF_KEY, KEY_FIRST, 4'hf);
    wr(OFF_KEY, KEY_SECOND, 4'hf);
    wr(OFF_CTRL, 32'h8003, 4'hf);
    rd(OFF_CTRL);
    // Address survives a plain reset only
    wr(OFF_ADDR, $urandom, 4'hf);
    rst(1'b0);
    rd(OFF_ADDR);
    rst(1'b1);
    rd(OFF_ADDR);
    close_out();
  end
endmodule : tb_top

// ### hw/fuar_pkg.sv
package fuar_pkg;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0]  OFF_KEY    = 8'h00;
  localparam logic [7:0]  OFF_ADDR   = 8'h04;
  localparam logic [7:0]  OFF_CTRL   = 8'h08;
  localparam logic [7:0]  OFF_STAT   = 8'h0c;
  localparam logic [7:0]  OFF_LAST   = 8'h10;

  // Control register layout
  localparam int          CTRL_OP_LSB = 0;
  localparam int          CTRL_GO_BIT = 15;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // Status register layout
  localparam int          STAT_ARMED_BIT   = 0;
  localparam int          STAT_REFUSED_BIT = 1;
  localparam int          STAT_USED_BIT    = 2;

  // Target address reset value (power-on only)
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // Operation select codes
  localparam logic [3:0]  OP_NONE = 4'h0;
  localparam logic [3:0]  OP_WORD = 4'h1;
  localparam logic [3:0]  OP_QUAD = 4'h2;
  localparam logic [3:0]  OP_ROW  = 4'h3;
  localparam logic [3:0]  OP_PAGE = 4'h4;

  // Address bits disregarded per operation
  localparam logic [31:0] MASK_PAGE = 32'h0000_3fff;
  localparam logic [31:0] MASK_ROW  = 32'h0000_07ff;
  localparam logic [31:0] MASK_WORD = 32'h0000_0003;
  localparam logic [31:0] MASK_QUAD = 32'h0000_000f;

  // Unlock key words; values are arbitrary
  localparam logic [31:0] KEY_FIRST  = 32'h1111_2222;
  localparam logic [31:0] KEY_SECOND = 32'h3333_4444;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // Unlock sequence state
  typedef enum logic [1:0] {LK_IDLE, LK_FIRST, LK_ARMED} fuar_lock_t;

  // Launch command towards the flash engine
  typedef struct packed {
    logic [3:0]  op;
    logic        addr_used;
    logic [31:0] addr;
  } fuar_launch_t;

endpackage : fuar_pkg

// ### hw/fuar_regs.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module fuar_regs
  import fuar_pkg::*;
(
  // Clock and resets
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_n,
  // AXI4-Lite write address
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic [2:0]   s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  // AXI4-Lite write response
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic [2:0]   s_axi_arprot,
  // AXI4-Lite read data
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // Launch command to the flash engine
  output logic              launch_valid,
  output fuar_launch_t      launch_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus channel state
  logic         aw_held_q, aw_held_d;
  logic [7:0]   awaddr_q,  awaddr_d;
  logic         w_held_q,  w_held_d;
  logic [31:0]  wdata_q,   wdata_d;
  logic [3:0]   wstrb_q,   wstrb_d;
  logic         bvalid_q,  bvalid_d;
  logic [1:0]   bresp_q,   bresp_d;
  logic         rvalid_q,  rvalid_d;
  logic [31:0]  rdata_q,   rdata_d;
  logic [1:0]   rresp_q,   rresp_d;

  // Register contents and unlock sequence
  logic [31:0]  addr_q,    addr_d;
  logic [31:0]  ctrl_q,    ctrl_d;
  fuar_lock_t   lock_q,    lock_d;
  logic         refused_q, refused_d;
  logic         go_q,      go_d;
  fuar_launch_t last_q,    last_d;

  // Decoded write and launch terms
  logic [31:0]  lane_mask;
  logic         wr_fire;
  logic         full_word;
  logic [31:0]  ctrl_new;
  logic [3:0]   op_new;
  logic         launch_go;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes of the pending write

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[8*gi +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  // Write happens once both halves are in and no response is pending
  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  assign full_word = (wstrb_q == 4'hf);
  assign ctrl_new  = (ctrl_q & ~lane_mask) | (wdata_q & lane_mask);
  assign op_new    = ctrl_new[CTRL_OP_LSB +: 4];
  assign launch_go = wr_fire && (awaddr_q == OFF_CTRL) && ctrl_new[CTRL_GO_BIT];

  // Bus handshakes; one transfer of each kind in flight
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign launch_valid  = go_q;
  assign launch_cmd    = last_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address masking by operation

  // Unused codes give a zero address, so a stray op aims nowhere
  function automatic fuar_launch_t mask_addr(input logic [3:0]  op,
                                             input logic [31:0] a);
    fuar_launch_t r;
    r.op        = op;
    r.addr_used = 1'b1;
    r.addr      = a;
    case (op)
      OP_PAGE: r.addr = a & ~MASK_PAGE;
      OP_ROW:  r.addr = a & ~MASK_ROW;
      OP_WORD: r.addr = a & ~MASK_WORD;
      OP_QUAD: r.addr = a & ~MASK_QUAD;
      default: begin
        r.addr_used = 1'b0;
        r.addr      = ZERO_WORD;
      end
    endcase
    return r;
  endfunction : mask_addr

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      // Both halves released together with the response
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      case (awaddr_q)
        OFF_KEY, OFF_ADDR, OFF_CTRL, OFF_STAT, OFF_LAST: bresp_d = RESP_OKAY;
        default:                                         bresp_d = RESP_SLVERR;
      endcase
    end
  end

  // Response waits for bready; the next write queues behind it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_held_q  <= 1'b0;
      wdata_q   <= ZERO_WORD;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken

  // Address decoded straight off the bus in the cycle it is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = ZERO_WORD;
      case (s_axi_araddr)
        OFF_KEY:  rdata_d = ZERO_WORD;
        OFF_ADDR: rdata_d = addr_q;
        OFF_CTRL: rdata_d = ctrl_q;
        OFF_STAT: begin
          rdata_d[STAT_ARMED_BIT]   = (lock_q == LK_ARMED);
          rdata_d[STAT_REFUSED_BIT] = refused_q;
          rdata_d[STAT_USED_BIT]    = last_q.addr_used;
        end
        OFF_LAST: rdata_d = last_q.addr;
        default:  rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // Read data registered so it stands steady while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= ZERO_WORD;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target address: survives every reset except power-on

  always_comb begin
    addr_d = addr_q;
    if (wr_fire && awaddr_q == OFF_ADDR) begin
      addr_d = (addr_q & ~lane_mask) | (wdata_q & lane_mask);
    end
  end

  // Kept out of the aresetn branch on purpose
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      addr_q <= ADDR_RESET;
    end else begin
      addr_q <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence, control and launch

  always_comb begin
    lock_d    = lock_q;
    ctrl_d    = ctrl_q;
    refused_d = refused_q;
    go_d      = 1'b0;
    last_d    = last_q;
    if (wr_fire) begin
      // Any register write outside the sequence disarms it
      lock_d = LK_IDLE;
      if (awaddr_q == OFF_KEY && full_word) begin
        if (wdata_q == KEY_FIRST) begin
          lock_d = LK_FIRST;
        end else if (lock_q == LK_FIRST && wdata_q == KEY_SECOND) begin
          lock_d = LK_ARMED;
        end
      end
      if (awaddr_q == OFF_CTRL) begin
        // Go bit is a command and never stored
        ctrl_d              = ctrl_new;
        ctrl_d[CTRL_GO_BIT] = 1'b0;
      end
    end
    if (launch_go) begin
      if (lock_q == LK_ARMED) begin
        // Operation written with the go bit counts
        go_d      = 1'b1;
        last_d    = mask_addr(op_new, addr_q);
        refused_d = 1'b0;
      end else begin
        refused_d = 1'b1;
      end
    end
  end

  // Plain reset drops a half-done unlock sequence as well
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q    <= LK_IDLE;
      ctrl_q    <= CTRL_RESET;
      refused_q <= 1'b0;
      go_q      <= 1'b0;
      last_q    <= '0;
    end else begin
      lock_q    <= lock_d;
      ctrl_q    <= ctrl_d;
      refused_q <= refused_d;
      go_q      <= go_d;
      last_q    <= last_d;
    end
  end

endmodule : fuar_regs
